// ===== logic/dmt_pkg.sv
package dmt_pkg;

   // Control word field positions.
   localparam int CTL_SEL_LSB = 0;
   localparam int CTL_SEL_MSB = 3;
   localparam int CTL_WR_BIT  = 4;
   localparam int CTL_RD_BIT  = 5;

   // Pattern select codes.
   localparam logic [3:0] SEL_ZERO  = 4'h0;
   localparam logic [3:0] SEL_ONES  = 4'h1;
   localparam logic [3:0] SEL_FIVES = 4'h2;
   localparam logic [3:0] SEL_AS    = 4'h3;
   localparam logic [3:0] SEL_COUNT = 4'h4;
   localparam logic [3:0] SEL_WALK  = 4'h8;

   // Fixed pattern words and generator start values.
   localparam logic [31:0] PAT_ZERO    = 32'h0000_0000;
   localparam logic [31:0] PAT_ONES    = 32'hFFFF_FFFF;
   localparam logic [31:0] PAT_FIVES   = 32'h5555_5555;
   localparam logic [31:0] PAT_AS      = 32'hAAAA_AAAA;
   localparam logic [31:0] WALK_START  = 32'h0000_0001;
   localparam logic [31:0] WALK_LAST   = 32'h8000_0000;
   localparam logic [31:0] COUNT_START = 32'h0000_0000;

   // Memory size in words and alive indicator timing.
   localparam longint MEM_WORDS      = 33554432;
   localparam int     ADDR_W         = 25;
   localparam int     CLK_HZ         = 25000000;
   localparam int     BLINK_MS       = 500;
   localparam int     BLINK_CYCLES   = CLK_HZ / 1000 * BLINK_MS;
   localparam int     FIFO_DEPTH     = 32;

   // Memory port request and command.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [24:0] addr;
      logic [31:0] data;
   } dmt_mem_req_s;

   typedef struct packed {
      logic [3:0] sel;
      logic       wr_en;
      logic       rd_en;
   } dmt_cmd_s;

endpackage

// ===== logic/dmt_fifo.sv
`timescale 1ns/10ps
module dmt_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wptr;
   logic [AW-1:0]    next_rptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Pointer and count update.
   always_comb begin
      next_wptr  = push ? wptr + AW'(1) : wptr;
      next_rptr  = pop ? rptr + AW'(1) : rptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end else begin
         wptr  <= next_wptr;
         rptr  <= next_rptr;
         count <= next_count;
      end
   end

   // Storage has no reset; only written words are ever read.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wptr] <= in_data_i;
      end
   end
endmodule

// ===== logic/dmt_top.sv
// Behaviour
// - Walking one starts at 1, shifts left each word, wraps after bit 31.
// - Count pattern starts at zero and adds one per word.
// - Fixed codes give zeros, ones, 55555555h and AAAAAAAAh.
// - A reading pass emits 33554432 words; it ends once the last word is in the output FIFO, before the host has drained them all.
// - Alive indicator toggles every 500 ms (BLINK_CYCLES of a 25 MHz clock) from the FIFO clock.
// - Input and output FIFO ports share one FIFO-side clock.
// - Memory side and FIFO side share clk_i, timed here as 25 MHz (CLK_HZ).
// - Control bits 3:0 select pattern, bit 4 write, bit 5 read.
// - Write all locations first, then read, check and forward each word.
// - Indicators show select bits; a mismatch lights all until reset.
`timescale 1ns/10ps
module dmt_top
   import dmt_pkg::*;
#(
   parameter longint WORDS        = MEM_WORDS,
   parameter int     BLINK_COUNT  = BLINK_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        shared_fifo_clock_option_i,
   input  wire logic        cmd_valid_i,
   output logic             cmd_ready_o,
   input  wire logic [31:0] cmd_data_i,
   output logic             out_valid_o,
   input  wire logic        out_ready_i,
   output logic      [31:0] out_data_o,
   output dmt_mem_req_s     mem_req_o,
   input  wire logic        mem_ack_i,
   input  wire logic        mem_rvalid_i,
   input  wire logic [31:0] mem_rdata_i,
   output logic      [3:0]  pattern_led_o,
   output logic             clock_alive_indicator_o,
   output logic             busy_o
);
   typedef enum logic [2:0] {S_IDLE, S_WRITE, S_RDREQ, S_RDWAIT, S_PUSH} dmt_state_e;

   dmt_state_e   state;
   dmt_state_e   next_state;
   dmt_cmd_s     cmd;
   dmt_cmd_s     next_cmd;
   logic [24:0]  addr;
   logic [24:0]  next_addr;
   logic [31:0]  gen;
   logic [31:0]  next_gen;
   logic [31:0]  rword;
   logic [31:0]  next_rword;
   logic         err;
   logic         next_err;
   logic         cmd_ready;
   logic         next_cmd_ready;
   dmt_mem_req_s req;
   dmt_mem_req_s next_req;
   logic         f_valid;
   logic         f_ready;
   logic         f_out_valid;
   logic [31:0]  f_out_data;
   logic [31:0]  blink;
   logic [31:0]  next_blink;
   logic         alive;
   logic         next_alive;
   logic [3:0]   leds;
   logic [3:0]   next_leds;
   logic         last_addr;

   // Both FIFO ports use clk_i; the option is accepted for pin compatibility only.
   logic         unused_opt;
   assign unused_opt = shared_fifo_clock_option_i;

   assign last_addr = (addr == 25'(WORDS - 1));

   // Pattern generator step: fixed words hold, count and walk advance.
   function automatic logic [31:0] pat_start(input logic [3:0] sel);
      unique case (sel)
         SEL_ZERO:  pat_start = PAT_ZERO;
         SEL_ONES:  pat_start = PAT_ONES;
         SEL_FIVES: pat_start = PAT_FIVES;
         SEL_AS:    pat_start = PAT_AS;
         SEL_COUNT: pat_start = COUNT_START;
         SEL_WALK:  pat_start = WALK_START;
         default:   pat_start = PAT_ZERO;
      endcase
   endfunction

   function automatic logic [31:0] pat_next(input logic [3:0] sel, input logic [31:0] v);
      if (sel == SEL_COUNT) begin
         pat_next = v + 32'h0000_0001;
      end else if (sel == SEL_WALK) begin
         pat_next = (v == WALK_LAST) ? WALK_START : {v[30:0], 1'b0};
      end else begin
         pat_next = v;
      end
   endfunction

   // Control sequence: idle, write all, then read, check and forward all.
   always_comb begin
      next_state     = state;
      next_cmd       = cmd;
      next_addr      = addr;
      next_gen       = gen;
      next_rword     = rword;
      next_err       = err;
      next_req       = req;
      next_cmd_ready = 1'b0;
      f_valid        = 1'b0;
      unique case (state)
         S_IDLE: begin
            next_cmd_ready = 1'b1;
            if (cmd_valid_i && cmd_ready) begin
               next_cmd_ready = 1'b0;
               next_cmd.sel   = cmd_data_i[CTL_SEL_MSB:CTL_SEL_LSB];
               next_cmd.wr_en = cmd_data_i[CTL_WR_BIT];
               next_cmd.rd_en = cmd_data_i[CTL_RD_BIT];
               next_addr      = '0;
               next_gen       = pat_start(cmd_data_i[CTL_SEL_MSB:CTL_SEL_LSB]);
               if (cmd_data_i[CTL_WR_BIT]) begin
                  next_state    = S_WRITE;
                  next_req.wr   = 1'b1;
                  next_req.rd   = 1'b0;
                  next_req.addr = '0;
                  next_req.data = pat_start(cmd_data_i[CTL_SEL_MSB:CTL_SEL_LSB]);
               end else if (cmd_data_i[CTL_RD_BIT]) begin
                  next_state    = S_RDREQ;
                  next_req.rd   = 1'b1;
                  next_req.wr   = 1'b0;
                  next_req.addr = '0;
               end else begin
                  next_cmd_ready = 1'b1;
               end
            end
         end
         S_WRITE: begin
            if (mem_ack_i) begin
               if (last_addr) begin
                  next_req.wr = 1'b0;
                  next_addr   = '0;
                  next_gen    = pat_start(cmd.sel);
                  if (cmd.rd_en) begin
                     next_state    = S_RDREQ;
                     next_req.rd   = 1'b1;
                     next_req.addr = '0;
                  end else begin
                     next_state     = S_IDLE;
                     next_cmd_ready = 1'b1;
                  end
               end else begin
                  next_addr     = addr + 25'h0000001;
                  next_gen      = pat_next(cmd.sel, gen);
                  next_req.addr = addr + 25'h0000001;
                  next_req.data = pat_next(cmd.sel, gen);
               end
            end
         end
         S_RDREQ: begin
            if (mem_ack_i) begin
               next_req.rd = 1'b0;
               next_state  = S_RDWAIT;
            end
         end
         S_RDWAIT: begin
            if (mem_rvalid_i) begin
               next_rword = mem_rdata_i;
               if (mem_rdata_i != gen) begin
                  next_err = 1'b1;
               end
               next_state = S_PUSH;
            end
         end
         S_PUSH: begin
            f_valid = 1'b1;
            if (f_ready) begin // Back-pressure from the host stalls the reads.
               if (last_addr) begin
                  next_state     = S_IDLE;
                  next_cmd_ready = 1'b1;
               end else begin
                  next_addr     = addr + 25'h0000001;
                  next_gen      = pat_next(cmd.sel, gen);
                  next_req.rd   = 1'b1;
                  next_req.addr = addr + 25'h0000001;
                  next_state    = S_RDREQ;
               end
            end
         end
      endcase
   end

   // One clock here; the memory request path is kept to one register stage for fast clocks.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state     <= S_IDLE;
         cmd       <= '0;
         addr      <= '0;
         gen       <= '0;
         rword     <= '0;
         err       <= 1'b0;
         req       <= '0;
         cmd_ready <= 1'b0;
      end else begin
         state     <= next_state;
         cmd       <= next_cmd;
         addr      <= next_addr;
         gen       <= next_gen;
         rword     <= next_rword;
         err       <= next_err;
         req       <= next_req;
         cmd_ready <= next_cmd_ready;
      end
   end

   // Output data buffer; its ready stalls the read sequence above.
   dmt_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_out_fifo (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (f_valid),
      .in_ready_o  (f_ready),
      .in_data_i   (rword),
      .out_valid_o (f_out_valid),
      .out_ready_i (out_ready_i),
      .out_data_o  (f_out_data)
   );

   // Indicator and alive blinker; error latch only clears at reset.
   always_comb begin
      next_leds  = err ? 4'hF : cmd.sel;
      next_blink = blink + 32'h0000_0001;
      next_alive = alive;
      if (blink >= 32'(BLINK_COUNT - 1)) begin
         next_blink = '0;
         next_alive = ~alive;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         leds  <= '0;
         blink <= '0;
         alive <= 1'b0;
      end else begin
         leds  <= next_leds;
         blink <= next_blink;
         alive <= next_alive;
      end
   end

   // The FIFO outputs are decoded combinationally from the buffer's count and storage.
   assign out_valid_o             = f_out_valid;
   assign out_data_o              = f_out_data;
   assign cmd_ready_o             = cmd_ready;
   assign mem_req_o               = req;
   assign pattern_led_o           = leds;
   assign clock_alive_indicator_o = alive;
   assign busy_o                  = (state != S_IDLE);

   // Checks beside the logic.
   a_walk_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == S_WRITE && mem_ack_i && !last_addr && cmd.sel == SEL_WALK && gen == WALK_LAST)
      |=> gen == WALK_START) else $error("walk did not wrap");
   a_count_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == S_WRITE && mem_ack_i && !last_addr && cmd.sel == SEL_COUNT)
      |=> gen == $past(gen) + 32'h0000_0001) else $error("count step wrong");
   a_fixed_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == S_WRITE && cmd.sel == SEL_FIVES) |-> req.data == PAT_FIVES)
      else $error("fixed pattern wrong");
   a_err_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      err |=> ##1 pattern_led_o == 4'hF) else $error("error leds off");
   a_err_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == S_RDWAIT && mem_rvalid_i && mem_rdata_i != gen) |=> err)
      else $error("mismatch missed");
   a_no_cmd_busy: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state != S_IDLE) |-> !cmd_ready) else $error("ready while busy");
   a_read_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == S_WRITE && next_state == S_RDREQ) |=> gen == pat_start(cmd.sel) && addr == '0)
      else $error("read not restarted");
   a_push_stall: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == S_PUSH && !f_ready) |=> state == S_PUSH) else $error("push lost");
   a_blink_toggle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (blink == 32'(BLINK_COUNT - 1)) |=> alive != $past(alive))
      else $error("alive did not toggle");

   c_write_pass: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      state == S_WRITE ##1 state == S_RDREQ);
   c_read_done:  cover property (@(posedge clk_i) disable iff (!reset_n_i)
      state == S_PUSH ##1 state == S_IDLE);
   c_error_seen: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(err));
   c_fifo_full:  cover property (@(posedge clk_i) disable iff (!reset_n_i) !f_ready);
endmodule

// ===== tb/dmt_mem_model.sv
`timescale 1ns/10ps
// Behavioural memory behind the request port; one 32-bit word per address.
module dmt_mem_model
   import dmt_pkg::*;
#(
   parameter int WORDS = 40
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  dmt_mem_req_s     req_i,
   input  wire logic        slow_i,
   input  wire logic        corrupt_i,
   output logic             ack_o,
   output logic             rvalid_o,
   output logic      [31:0] rdata_o
);
   logic [31:0] mem [WORDS];
   logic [31:0] word;
   logic [2:0]  wait_cnt;
   logic [2:0]  rd_cnt;
   logic        rd_pend;

   // Between beats the data lines show the inverse of the last word, so stale data never matches.
   assign rdata_o = rvalid_o ? word : ~word;

   // Ack is a one-cycle pulse and stays low for a cycle after, so a held request is taken once.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_o    <= 1'b0;
         rvalid_o <= 1'b0;
         rd_pend  <= 1'b0;
         wait_cnt <= 3'h0;
         rd_cnt   <= 3'h0;
         word     <= 32'h0;
      end else begin
         ack_o    <= 1'b0;
         rvalid_o <= 1'b0;
         if (rd_pend) begin
            if (rd_cnt == 3'h0) begin
               rvalid_o <= 1'b1;
               rd_pend  <= 1'b0;
            end else begin
               rd_cnt <= rd_cnt - 3'h1;
            end
         end else if (!ack_o && (req_i.wr || req_i.rd)) begin
            if (wait_cnt != 3'h0) begin
               wait_cnt <= wait_cnt - 3'h1;
            end else begin
               ack_o    <= 1'b1;
               wait_cnt <= slow_i ? 3'h3 : 3'h0;
               if (req_i.wr) begin
                  mem[int'(req_i.addr)] <= req_i.data;
               end else begin
                  // A deliberate bit error at address 3 lets the bench reach the compare failure.
                  word    <= mem[int'(req_i.addr)] ^ {31'h0, corrupt_i && req_i.addr == 25'h3};
                  rd_pend <= 1'b1;
                  rd_cnt  <= slow_i ? 3'h4 : 3'h1;
               end
            end
         end
      end
   end
endmodule

// ===== tb/dmt_top_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench acting as the host on the command and output ports.
module dmt_top_tb_top
   import dmt_pkg::*;
;
   localparam longint NW = 40;
   localparam int     BK = 4;
   logic         clk_i = 1'b0;
   logic         reset_n_i = 1'b0;
   logic         cmd_valid_i = 1'b0;
   logic         out_ready_i = 1'b0;
   logic         slow = 1'b0;
   logic         corrupt = 1'b0;
   logic  [31:0] cmd_data_i = 32'h0;
   logic         cmd_ready_o;
   logic         out_valid_o;
   logic  [31:0] out_data_o;
   dmt_mem_req_s mem_req;
   logic         mem_ack;
   logic         mem_rvalid;
   logic  [31:0] mem_rdata;
   logic  [3:0]  led;
   logic         alive;
   logic         busy_o;
   int           err_count = 0;
   int           cmp_count = 0;

   // Free-running clock at 40 ns.
   always #20 clk_i = ~clk_i;

   dmt_top #(.WORDS(NW), .BLINK_COUNT(BK)) uut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .shared_fifo_clock_option_i(1'b1),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_data_i(cmd_data_i),
      .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
      .mem_req_o(mem_req), .mem_ack_i(mem_ack), .mem_rvalid_i(mem_rvalid),
      .mem_rdata_i(mem_rdata), .pattern_led_o(led), .clock_alive_indicator_o(alive),
      .busy_o(busy_o));

   dmt_mem_model #(.WORDS(int'(NW))) mem (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(mem_req), .slow_i(slow),
      .corrupt_i(corrupt), .ack_o(mem_ack), .rvalid_o(mem_rvalid), .rdata_o(mem_rdata));

   // Shared compare, verdict and hang handling.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic timeout();
      err_count++;
      $display("Error at %0t: wait ran out, seen %h expected %h", $time, 1'b0, 1'b1);
      close_out();
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      #1 reset_n_i = 1'b0;
      repeat (5) @(posedge clk_i);
      chk({27'h0, led, alive}, 32'h0);
      #1 reset_n_i = 1'b1;
   endtask

   // Expected word i of a pass, worked out from the pattern codes.
   function automatic logic [31:0] expv(input logic [3:0] s, input int i);
      case (s)
         SEL_ONES:  return PAT_ONES;
         SEL_FIVES: return PAT_FIVES;
         SEL_AS:    return PAT_AS;
         SEL_COUNT: return COUNT_START + 32'(i);
         SEL_WALK:  return WALK_START << (i % 32);
         default:   return PAT_ZERO;
      endcase
   endfunction

   // Holds the command until taken; the host sends one word per pass.
   task automatic send_cmd(input logic [31:0] w);
      int n;
      @(posedge clk_i);
      #1 cmd_valid_i = 1'b1;
      cmd_data_i = w;
      for (n = 0; n < 100 && cmd_ready_o !== 1'b1; n++) @(negedge clk_i);
      if (n == 100) timeout();
      @(posedge clk_i);
      #1 cmd_valid_i = 1'b0;
      chk({30'h0, busy_o, cmd_ready_o}, 32'h2);
   endtask

   // Takes exactly NW words, stalling first; word bad carries the injected flip.
   task automatic get_words(input logic [3:0] s, input int bad, input int stall);
      int i;
      int n;
      i = 0;
      for (n = 0; n < 20000 && i < NW; n++) begin
         @(posedge clk_i);
         #1 out_ready_i = (n >= stall);
         @(negedge clk_i);
         if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            chk(out_data_o, expv(s, i) ^ 32'(i == bad));
            i++;
         end
      end
      if (i < NW) timeout();
      // Let the last word pop, then stall the host again for later scenarios.
      @(posedge clk_i);
      #1 out_ready_i = 1'b0;
      for (n = 0; n < 50 && busy_o !== 1'b0; n++) @(negedge clk_i);
      if (n == 50) timeout();
      repeat (4) begin
         @(negedge clk_i);
         chk({31'h0, out_valid_o}, 32'h0);
      end
   endtask

   // The alive indicator must toggle at a fixed spacing.
   task automatic t_blink();
      logic last;
      int   at;
      int   tg;
      last = alive;
      at = -1;
      tg = 0;
      for (int n = 1; n <= 40; n++) begin
         @(negedge clk_i);
         if (alive !== last) begin
            if (at >= 0) chk(32'(n - at), 32'(BK));
            at = n;
            tg++;
            last = alive;
         end
      end
      chk({31'h0, tg >= 9}, 32'h1);
      $display("Test blink done");
   endtask

   // Five loops over all six codes, each a write-then-read pass.
   task automatic t_patterns();
      logic [3:0] sels [6] = '{SEL_ZERO, SEL_ONES, SEL_FIVES, SEL_AS, SEL_COUNT, SEL_WALK};
      for (int l = 0; l < 5; l++) begin
         for (int p = 0; p < 6; p++) begin
            send_cmd({26'h0, 2'b11, sels[p]});
            get_words(sels[p], -1, 0);
            chk({28'h0, led}, {28'h0, sels[p]});
         end
      end
      $display("Test patterns done");
   endtask

   // Slow memory and a stalled host fill the output buffer; a second command is refused.
   task automatic t_stall();
      slow = 1'b1;
      send_cmd(32'h34);
      @(posedge clk_i);
      #1 cmd_valid_i = 1'b1;
      cmd_data_i = 32'h38;
      repeat (6) begin
         @(negedge clk_i);
         chk({31'h0, cmd_ready_o}, 32'h0);
      end
      @(posedge clk_i);
      #1 cmd_valid_i = 1'b0;
      repeat (600) @(posedge clk_i);
      chk({30'h0, busy_o, out_valid_o}, 32'h3);
      get_words(SEL_COUNT, -1, 0);
      slow = 1'b0;
      $display("Test stall done");
   endtask

   // Write-only pass gives no output; a later read-only pass finds the count.
   task automatic t_split();
      logic seen;
      seen = 1'b0;
      send_cmd(32'h14);
      for (int n = 0; n < 500 && busy_o !== 1'b0; n++) begin
         @(negedge clk_i);
         if (out_valid_o === 1'b1) seen = 1'b1;
      end
      chk({31'h0, seen | busy_o}, 32'h0);
      send_cmd(32'h24);
      get_words(SEL_COUNT, -1, 0);
      $display("Test split done");
   endtask

   // A read error lights all indicators until reset; words still flow.
   task automatic t_error();
      corrupt = 1'b1;
      send_cmd(32'h31);
      get_words(SEL_ONES, 3, 0);
      chk({28'h0, led}, 32'hF);
      corrupt = 1'b0;
      send_cmd(32'h32);
      get_words(SEL_FIVES, -1, 0);
      chk({28'h0, led}, 32'hF);
      do_reset();
      $display("Test error done");
   endtask

   // Main sequence.
   initial begin
      do_reset();
      t_blink();
      t_patterns();
      t_stall();
      t_split();
      t_error();
      close_out();
   end
endmodule
